/* mph_param_handler.sv */
// Behaviour
// - connection state reported as byte 1,2,3,4,6,7,9,10 by state kind
// - frame length answer: 0x8A, 0x03, error, length 5, id, 32-bit ms
// - new join key goes to storage; active key changes only after reset
// - join key answer: 0x88, 0x04, error, length 0
// - join key is set-only; frame length, time, properties are get-only
// - time/state answer carries the same content as the unsolicited packet
// - time/state answer: length 0x17, time fields, state at byte 26
// - property answer: 0x8A, 0x07, error, length 0x1F, fields
// - property fields in fixed order, ending with one reserved byte
// - 0x7D and 0x7E escaped as 0x7D 0x5D / 0x7D 0x5E, reversed on receive
// - ones-complement CRC-16 over unstuffed payload, low byte first
// - each packet opens and closes with a 0x7E flag
// - non-zero error code forces data length zero and no data
`timescale 1ns/1ps
`include "mph_consts.svh"

module mph_param_handler import mph_pkg::*; #(
    parameter int RX_DEPTH = `MPH_RX_DEPTH
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire mph_conn_t conn_state,
    output logic [7:0] frame_id,
    input wire logic [31:0] frame_len_ms,
    input wire logic [31:0] ts_cycle,
    input wire logic [31:0] ts_offset_us,
    input wire logic [15:0] ts_frame_slots,
    input wire logic [31:0] ts_utc_s,
    input wire logic [31:0] ts_utc_us,
    input wire logic [31:0] ts_uptime_ms,
    input wire logic [23:0] prop_hw_model,
    input wire logic [15:0] prop_hw_rev,
    input wire logic [31:0] prop_sw_rev,
    input wire logic [63:0] prop_mac,
    input wire logic [7:0] prop_net_type,
    input wire logic [15:0] prop_net_id,
    input wire logic [63:0] prop_sheet_id,
    input wire logic [15:0] prop_node_id,
    output logic key_store_we,
    output logic [127:0] key_store_data,
    input wire logic [127:0] key_nv,
    output logic [127:0] key_active
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (RX_DEPTH < 20 || RX_DEPTH > 63) begin : g_bad_depth
        $error("RX_DEPTH must hold a key request and fit a 6-bit count");
    end

    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ `MPH_CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    function automatic logic [7:0] state_code(input mph_conn_t s);
        case (s)
            MPH_CS_WAIT_CFG: state_code = 8'h01;
            MPH_CS_JOINING: state_code = 8'h02;
            MPH_CS_ACTIVE_NEIGHBOR_SCAN: state_code = 8'h03;
            MPH_CS_PASSIVE_NEIGHBOR_SCAN: state_code = 8'h04;
            MPH_CS_SYNCHRONIZED: state_code = 8'h06;
            MPH_CS_RESETTING: state_code = 8'h07;
            MPH_CS_ONLINE_SINGLE_PARENT: state_code = 8'h09;
            MPH_CS_ONLINE_MULTI_PARENT: state_code = 8'h0A;
            default: state_code = 8'h01;
        endcase
    endfunction

    // ----------------------------------------
    // receive: deframe, unstuff, check, decode
    // ----------------------------------------
    logic [7:0] rx_buf_r [0:RX_DEPTH-1];
    logic [7:0] rx_buf_nxt [0:RX_DEPTH-1];
    logic [5:0] rx_cnt_r, rx_cnt_nxt;
    logic [15:0] rx_crc_r, rx_crc_nxt;
    logic rx_esc_r, rx_esc_nxt, rx_ovf_r, rx_ovf_nxt;
    logic [7:0] resp_r [0:`MPH_RSP_BYTES-1];
    logic [7:0] resp_nxt [0:`MPH_RSP_BYTES-1];
    logic [5:0] resp_len_r, resp_len_nxt;
    logic key_we_r, key_we_nxt;
    logic [127:0] key_data_r, key_data_nxt;
    logic [127:0] key_act_r;
    logic key_load_r;
    logic start;
    mph_tx_state_t tx_state_r, tx_state_nxt;

    always_comb begin
        logic [7:0] d, err, dlen, code;
        logic [247:0] vec;
        logic [5:0] plen;
        logic frame_end, is_get, is_set;
        rx_buf_nxt = rx_buf_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_crc_nxt = rx_crc_r;
        rx_esc_nxt = rx_esc_r;
        rx_ovf_nxt = rx_ovf_r;
        resp_nxt = resp_r;
        resp_len_nxt = resp_len_r;
        key_we_nxt = 1'b0;
        key_data_nxt = key_data_r;
        d = rx_esc_r ? (rx_byte ^ `MPH_ESC_XOR) : rx_byte;
        frame_end = 1'b0;
        if (rx_valid) begin
            if (rx_byte == `MPH_FLAG) begin
                // bad CRC, overflow or busy transmitter drop the request silently
                frame_end = rx_cnt_r >= 6'd4 && !rx_ovf_r && !rx_esc_r &&
                            rx_crc_r == `MPH_CRC_GOOD && tx_state_r == MPH_TX_IDLE;
                rx_cnt_nxt = 6'd0;
                rx_crc_nxt = `MPH_CRC_INIT;
                rx_esc_nxt = 1'b0;
                rx_ovf_nxt = 1'b0;
            end else if (rx_byte == `MPH_ESC && !rx_esc_r) begin
                rx_esc_nxt = 1'b1;
            end else begin
                rx_esc_nxt = 1'b0;
                if (rx_cnt_r < 6'(RX_DEPTH)) begin
                    rx_buf_nxt[rx_cnt_r] = d;
                    rx_cnt_nxt = rx_cnt_r + 6'd1;
                    rx_crc_nxt = crc_upd(rx_crc_r, d);
                end else begin
                    rx_ovf_nxt = 1'b1;
                end
            end
        end
        is_get = rx_buf_r[0] == `MPH_CMD_GET;
        is_set = rx_buf_r[0] == `MPH_CMD_SET;
        start = frame_end && (is_get || is_set);
        plen = rx_cnt_r - 6'd2;
        err = `MPH_ERR_PARAM;
        dlen = 8'h00;
        vec = '0;
        code = is_get ? `MPH_RSP_GET : `MPH_RSP_SET;
        if (is_get) begin
            case (rx_buf_r[1])
                `MPH_PAR_STATE: begin
                    err = `MPH_ERR_NONE;
                    dlen = `MPH_LEN_STATE;
                    vec[247:240] = state_code(conn_state);
                end
                `MPH_PAR_FLEN: begin
                    if (plen >= `MPH_PLEN_FLEN) begin
                        err = `MPH_ERR_NONE;
                        dlen = `MPH_LEN_FLEN;
                        vec[247:208] = {rx_buf_r[2], frame_len_ms};
                    end
                end
                `MPH_PAR_TIME: begin
                    err = `MPH_ERR_NONE;
                    dlen = `MPH_LEN_TIME;
                    // same field layout as the unsolicited time packet
                    vec[247:64] = {ts_cycle, ts_offset_us, ts_frame_slots, ts_utc_s,
                                   ts_utc_us, ts_uptime_ms, state_code(conn_state)};
                end
                `MPH_PAR_PROP: begin
                    err = `MPH_ERR_NONE;
                    dlen = `MPH_LEN_PROP;
                    vec = {prop_hw_model, prop_hw_rev, prop_sw_rev, prop_mac, prop_net_type,
                           prop_net_id, prop_sheet_id, prop_node_id, 8'h00};
                end
                default: begin
                    err = `MPH_ERR_PARAM;
                end
            endcase
        end else if (rx_buf_r[1] == `MPH_PAR_KEY && plen >= `MPH_PLEN_KEY) begin
            err = `MPH_ERR_NONE;
            dlen = `MPH_LEN_KEY;
            key_we_nxt = start;
            for (int i = 0; i < `MPH_KEY_BYTES; i++) begin
                key_data_nxt[127-8*i -: 8] = start ? rx_buf_r[2+i] : key_data_r[127-8*i -: 8];
            end
        end
        if (err != `MPH_ERR_NONE) begin
            dlen = 8'h00;
            vec = '0;
        end
        if (start) begin
            resp_nxt[0] = code;
            resp_nxt[1] = rx_buf_r[1];
            resp_nxt[2] = err;
            resp_nxt[3] = dlen;
            for (int i = 0; i < `MPH_DATA_BYTES; i++) begin
                resp_nxt[4+i] = vec[247-8*i -: 8];
            end
            resp_len_nxt = `MPH_HDR_BYTES + dlen[5:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int i = 0; i < RX_DEPTH; i++) begin
                rx_buf_r[i] <= 8'h00;
            end
            for (int i = 0; i < `MPH_RSP_BYTES; i++) begin
                resp_r[i] <= 8'h00;
            end
            rx_cnt_r <= 6'h00;
            rx_crc_r <= `MPH_CRC_INIT;
            rx_esc_r <= 1'b0;
            rx_ovf_r <= 1'b0;
            resp_len_r <= 6'h00;
            key_we_r <= 1'b0;
            key_data_r <= '0;
        end else begin
            rx_buf_r <= rx_buf_nxt;
            resp_r <= resp_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_crc_r <= rx_crc_nxt;
            rx_esc_r <= rx_esc_nxt;
            rx_ovf_r <= rx_ovf_nxt;
            resp_len_r <= resp_len_nxt;
            key_we_r <= key_we_nxt;
            key_data_r <= key_data_nxt;
        end
    end

    // ----------------------------------------
    // active key: caught from storage once after reset release
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            key_load_r <= 1'b1;
            key_act_r <= '0;
        end else if (key_load_r) begin
            key_load_r <= 1'b0;
            key_act_r <= key_nv;
        end
    end

    // ----------------------------------------
    // transmit: frame, CRC, stuff
    // ----------------------------------------
    logic [5:0] tx_idx_r, tx_idx_nxt;
    logic [15:0] tx_crc_r, tx_crc_nxt;
    logic tx_esc_r, tx_esc_nxt, tx_valid_r, tx_valid_nxt;
    logic [7:0] tx_byte_r, tx_byte_nxt;

    always_comb begin
        logic [7:0] raw;
        logic adv;
        raw = `MPH_FLAG;
        tx_state_nxt = tx_state_r;
        tx_idx_nxt = tx_idx_r;
        tx_crc_nxt = tx_crc_r;
        tx_esc_nxt = tx_esc_r;
        tx_byte_nxt = tx_byte_r;
        tx_valid_nxt = tx_valid_r && !tx_ready;
        adv = 1'b0;
        case (tx_state_r)
            MPH_TX_BODY: raw = resp_r[tx_idx_r];
            MPH_TX_CRC_LO: raw = ~tx_crc_r[7:0];
            MPH_TX_CRC_HI: raw = ~tx_crc_r[15:8];
            default: raw = `MPH_FLAG;
        endcase
        if (start) begin
            tx_state_nxt = MPH_TX_SOF;
            tx_idx_nxt = 6'h00;
            tx_crc_nxt = `MPH_CRC_INIT;
            tx_esc_nxt = 1'b0;
        end else if (tx_state_r != MPH_TX_IDLE && (!tx_valid_r || tx_ready)) begin
            tx_valid_nxt = 1'b1;
            if (tx_state_r == MPH_TX_SOF || tx_state_r == MPH_TX_EOF) begin
                tx_byte_nxt = `MPH_FLAG;
                tx_state_nxt = (tx_state_r == MPH_TX_SOF) ? MPH_TX_BODY : MPH_TX_IDLE;
            end else if (tx_esc_r) begin
                tx_byte_nxt = raw ^ `MPH_ESC_XOR;
                tx_esc_nxt = 1'b0;
                adv = 1'b1;
            end else begin
                if (tx_state_r == MPH_TX_BODY) begin
                    tx_crc_nxt = crc_upd(tx_crc_r, raw);
                end
                if (raw == `MPH_FLAG || raw == `MPH_ESC) begin
                    tx_byte_nxt = `MPH_ESC;
                    tx_esc_nxt = 1'b1;
                end else begin
                    tx_byte_nxt = raw;
                    adv = 1'b1;
                end
            end
            if (adv) begin
                case (tx_state_r)
                    MPH_TX_BODY: begin
                        if (tx_idx_r == resp_len_r - 6'd1) begin
                            tx_state_nxt = MPH_TX_CRC_LO;
                        end else begin
                            tx_idx_nxt = tx_idx_r + 6'd1;
                        end
                    end
                    MPH_TX_CRC_LO: tx_state_nxt = MPH_TX_CRC_HI;
                    MPH_TX_CRC_HI: tx_state_nxt = MPH_TX_EOF;
                    default: tx_state_nxt = tx_state_r;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tx_state_r <= MPH_TX_IDLE;
            tx_idx_r <= 6'h00;
            tx_crc_r <= `MPH_CRC_INIT;
            tx_esc_r <= 1'b0;
            tx_valid_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_idx_r <= tx_idx_nxt;
            tx_crc_r <= tx_crc_nxt;
            tx_esc_r <= tx_esc_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_byte_r <= tx_byte_nxt;
        end
    end

    assign tx_byte = tx_byte_r;
    assign tx_valid = tx_valid_r;
    assign frame_id = rx_buf_r[2];
    assign key_store_we = key_we_r;
    assign key_store_data = key_data_r;
    assign key_active = key_act_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_key_held: assert property (@(posedge mclk) disable iff (!reset_n)
        !key_load_r |=> $stable(key_act_r)) else $error("active key changed after load");
    a_key_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        start && key_we_nxt |=> key_store_we && resp_r[0] == 8'h88 && resp_r[3] == 8'h00)
        else $error("join key answer wrong");
    a_flen_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        start && rx_buf_r[0] == 8'h89 && rx_buf_r[1] == 8'h03 && rx_cnt_r >= 6'd5
        |=> resp_r[0] == 8'h8A && resp_r[3] == 8'h05 && resp_len_r == 6'd9)
        else $error("frame length answer wrong");
    a_time_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        start && rx_buf_r[0] == 8'h89 && rx_buf_r[1] == 8'h05
        |=> resp_r[3] == 8'h17 && resp_r[`MPH_STATE_IDX] == state_code($past(conn_state)))
        else $error("time answer wrong");
    a_prop_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        start && rx_buf_r[0] == 8'h89 && rx_buf_r[1] == 8'h07
        |=> resp_r[3] == 8'h1F && resp_len_r == 6'd35 && resp_r[34] == 8'h00)
        else $error("property answer wrong");
    a_wrong_dir: assert property (@(posedge mclk) disable iff (!reset_n)
        start && rx_buf_r[0] == 8'h87 && rx_buf_r[1] == 8'h03 |=> resp_r[2] == 8'h02)
        else $error("wrong direction not refused");
    a_err_nodata: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(tx_state_r == MPH_TX_SOF) && resp_r[2] != 8'h00 |-> resp_r[3] == 8'h00
        && resp_len_r == 6'd4) else $error("error answer carries data");
    a_esc_pair: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_valid && tx_ready && tx_byte == 8'h7D && tx_state_r != MPH_TX_IDLE
        |=> tx_valid && (tx_byte == 8'h5D || tx_byte == 8'h5E)) else $error("bad escape pair");
    a_sof_flag: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_state_r == MPH_TX_SOF && (!tx_valid || tx_ready) |=> tx_valid && tx_byte == 8'h7E
        && tx_state_r == MPH_TX_BODY) else $error("missing opening flag");

endmodule

/* mph_consts.svh */
`ifndef MPH_CONSTS_SVH
`define MPH_CONSTS_SVH

// ----------------------------------------
// framing
// ----------------------------------------
`define MPH_FLAG 8'h7E
`define MPH_ESC 8'h7D
`define MPH_ESC_XOR 8'h20
`define MPH_CRC_INIT 16'hFFFF
`define MPH_CRC_POLY 16'h8408
`define MPH_CRC_GOOD 16'hF0B8

// ----------------------------------------
// command and parameter codes
// ----------------------------------------
`define MPH_CMD_SET 8'h87
`define MPH_RSP_SET 8'h88
`define MPH_CMD_GET 8'h89
`define MPH_RSP_GET 8'h8A
`define MPH_PAR_STATE 8'h02
`define MPH_PAR_FLEN 8'h03
`define MPH_PAR_KEY 8'h04
`define MPH_PAR_TIME 8'h05
`define MPH_PAR_PROP 8'h07
`define MPH_ERR_NONE 8'h00
`define MPH_ERR_PARAM 8'h02

// ----------------------------------------
// data lengths and request sizes
// ----------------------------------------
`define MPH_LEN_STATE 8'h01
`define MPH_LEN_FLEN 8'h05
`define MPH_LEN_KEY 8'h00
`define MPH_LEN_TIME 8'h17
`define MPH_LEN_PROP 8'h1F
`define MPH_PLEN_FLEN 6'h03
`define MPH_PLEN_KEY 6'h12
`define MPH_HDR_BYTES 6'h04
`define MPH_RSP_BYTES 35
`define MPH_DATA_BYTES 31
`define MPH_KEY_BYTES 16
`define MPH_STATE_IDX 26
`define MPH_RX_DEPTH 37

`endif

/* mph_pkg.sv */
package mph_pkg;
    // link-level connection state as kept by the networking core
    typedef enum logic [2:0] {
        MPH_CS_WAIT_CFG = 3'h0,
        MPH_CS_JOINING = 3'h1,
        MPH_CS_ACTIVE_NEIGHBOR_SCAN = 3'h2,
        MPH_CS_PASSIVE_NEIGHBOR_SCAN = 3'h3,
        MPH_CS_SYNCHRONIZED = 3'h4,
        MPH_CS_RESETTING = 3'h5,
        MPH_CS_ONLINE_SINGLE_PARENT = 3'h6,
        MPH_CS_ONLINE_MULTI_PARENT = 3'h7
    } mph_conn_t;

    typedef enum logic [5:0] {
        MPH_TX_IDLE = 6'b000001,
        MPH_TX_SOF = 6'b000010,
        MPH_TX_BODY = 6'b000100,
        MPH_TX_CRC_LO = 6'b001000,
        MPH_TX_CRC_HI = 6'b010000,
        MPH_TX_EOF = 6'b100000
    } mph_tx_state_t;
endpackage

/* mph_host_model.sv */
`timescale 1ns/1ps

module mph_host_model (
    input wire logic mclk,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic slow,
    input wire logic ready_rnd,
    output logic frame_done,
    output logic frame_ok
);
    logic [7:0] cur[$];
    logic [7:0] frame_q[$];
    logic [15:0] rc;
    logic esc = 1'b0;
    logic open_f = 1'b0;
    logic bad = 1'b0;

    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
        frame_done = 1'b0;
        frame_ok = 1'b0;
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        return c;
    endfunction

    // ----------------------------------------
    // request side
    // ----------------------------------------
    // corrupt flips one crc bit so the frame must be dropped
    task automatic send(input logic [7:0] req[$], input logic corrupt);
        logic [7:0] p[$];
        logic [7:0] line[$];
        logic [15:0] c;
        p = req;
        c = 16'hFFFF;
        foreach (p[i]) c = crc_step(c, p[i]);
        c = ~c ^ {15'h0000, corrupt};
        p.push_back(c[7:0]);
        p.push_back(c[15:8]);
        line.push_back(8'h7E);
        foreach (p[i]) begin
            if (p[i] == 8'h7D || p[i] == 8'h7E) begin
                line.push_back(8'h7D);
                line.push_back(p[i] ^ 8'h20);
            end else begin
                line.push_back(p[i]);
            end
        end
        line.push_back(8'h7E);
        foreach (line[i]) begin
            @(posedge mclk);
            rx_byte <= line[i];
            rx_valid <= 1'b1;
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        // idle line shows the inverse of the last flag, not a stale copy
        rx_byte <= 8'h81;
    endtask

    // ----------------------------------------
    // reply side: unstuff, check flags and crc residue
    // ----------------------------------------
    always @(posedge mclk) begin
        tx_ready <= slow ? ready_rnd : 1'b1;
        frame_done <= 1'b0;
        if (tx_valid && tx_ready) begin
            if (tx_byte == 8'h7E) begin
                if (open_f && cur.size() > 0) begin
                    rc = 16'hFFFF;
                    foreach (cur[i]) rc = crc_step(rc, cur[i]);
                    frame_ok <= (rc == 16'hF0B8) && !bad && !esc;
                    frame_q = cur;
                    frame_done <= 1'b1;
                    open_f = 1'b0;
                    bad = 1'b0;
                end else begin
                    open_f = 1'b1;
                end
                cur.delete();
                esc = 1'b0;
            end else if (!open_f) begin
                bad = 1'b1;
            end else if (esc) begin
                if (tx_byte != 8'h5D && tx_byte != 8'h5E) bad = 1'b1;
                cur.push_back(tx_byte ^ 8'h20);
                esc = 1'b0;
            end else if (tx_byte == 8'h7D) begin
                esc = 1'b1;
            end else begin
                cur.push_back(tx_byte);
            end
        end
    end
endmodule

/* mph_param_handler_tb_top.sv */
`timescale 1ns/1ps
`include "mph_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module mph_param_handler_tb_top import mph_pkg::*; ;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] rx_byte, tx_byte, frame_id;
    logic rx_valid, tx_valid, tx_ready, key_store_we, frame_done, frame_ok;
    logic slow = 1'b0;
    mph_conn_t conn_state = MPH_CS_WAIT_CFG;
    logic [31:0] frame_len_ms = 32'h0, ts_cycle = 32'h0, ts_offset_us = 32'h0;
    logic [31:0] ts_utc_s = 32'h0, ts_utc_us = 32'h0, ts_uptime_ms = 32'h0;
    logic [15:0] ts_frame_slots = 16'h0, prop_hw_rev = 16'h0;
    logic [15:0] prop_net_id = 16'h0, prop_node_id = 16'h0;
    logic [23:0] prop_hw_model = 24'h0;
    logic [31:0] prop_sw_rev = 32'h0;
    logic [63:0] prop_mac = 64'h0, prop_sheet_id = 64'h0;
    logic [7:0] prop_net_type = 8'h01;
    logic [127:0] key_store_data, key_active;
    logic [127:0] key_nv = 128'h0;
    logic [15:0] seed = 16'h003D;
    logic [15:0] rdy_s = 16'h003D;
    logic [7:0] exp_q[$];
    logic [7:0] e8;
    int exp_len[$];
    int pend = 0;
    int n;
    int we_cnt = 0;
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] codes[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A};
    logic [7:0] bcmd[7] = '{8'h89, 8'h87, 8'h87, 8'h87, 8'h89, 8'h87, 8'h89};
    logic [7:0] bpar[7] = '{8'h04, 8'h03, 8'h05, 8'h07, 8'h06, 8'h01, 8'h03};

    always #2.5 mclk = ~mclk;

    mph_param_handler mph_param_handler_i (.mclk(mclk), .reset_n(reset_n),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .conn_state(conn_state), .frame_id(frame_id),
        .frame_len_ms(frame_len_ms), .ts_cycle(ts_cycle), .ts_offset_us(ts_offset_us),
        .ts_frame_slots(ts_frame_slots), .ts_utc_s(ts_utc_s), .ts_utc_us(ts_utc_us),
        .ts_uptime_ms(ts_uptime_ms), .prop_hw_model(prop_hw_model),
        .prop_hw_rev(prop_hw_rev), .prop_sw_rev(prop_sw_rev), .prop_mac(prop_mac),
        .prop_net_type(prop_net_type), .prop_net_id(prop_net_id),
        .prop_sheet_id(prop_sheet_id), .prop_node_id(prop_node_id),
        .key_store_we(key_store_we), .key_store_data(key_store_data), .key_nv(key_nv),
        .key_active(key_active));

    mph_host_model mph_host_model_i (.mclk(mclk), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow),
        .ready_rnd(rdy_s[0]), .frame_done(frame_done), .frame_ok(frame_ok));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rnd(output logic [63:0] r);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            r = {r[47:0], seed};
        end
    endtask

    // wide enough for the nine-byte frame length answer and field groups
    task automatic put(input logic [71:0] v, input int nb);
        for (int i = nb - 1; i >= 0; i--) begin
            exp_q.push_back(v[8*i +: 8]);
            pend++;
        end
    endtask

    task automatic results();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the reply must be fully out before the next request is legal
    task automatic ask(input logic [7:0] req[$]);
        exp_len.push_back(pend);
        pend = 0;
        mph_host_model_i.send(req, 1'b0);
        for (int i = 0; i < 3000 && exp_len.size() > 0; i++) @(posedge mclk);
        if (exp_len.size() > 0) begin
            fail_count++;
            results();
        end
        repeat (4) @(posedge mclk);
    endtask

    task automatic pulse_reset();
        reset_n <= 1'b0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    // ----------------------------------------
    // storage, stall source and reply checker
    // ----------------------------------------
    always @(posedge mclk) begin
        rdy_s <= lfsr_next(rdy_s);
        if (key_store_we === 1'b1) begin
            we_cnt++;
            key_nv <= key_store_data;
        end
    end

    always @(posedge mclk) begin
        if (frame_done) begin
            if (exp_len.size() == 0) begin
                fail_count++;
                $display("MISMATCH t=%0t got=%0h exp=%0h", $time, 1, 0);
            end else begin
                n = exp_len.pop_front();
                `CHK(frame_ok, 1'b1)
                `CHK(mph_host_model_i.frame_q.size(), n + 2)
                for (int i = 0; i < n; i++) begin
                    e8 = exp_q.pop_front();
                    `CHK(mph_host_model_i.frame_q[i], e8)
                end
            end
        end
    end

    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        results();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [63:0] r, r2, r3, r4;
        logic [127:0] k0, k1;
        logic [7:0] req[$];
        logic [7:0] fid;
        rnd(r);
        rnd(r2);
        k0 = {r, r2};
        key_nv <= k0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK(key_active, k0)
        for (int s = 0; s < 8; s++) begin
            conn_state <= mph_conn_t'(s[2:0]);
            put({8'h8A, 8'h02, 8'h00, 8'h01, codes[s]}, 5);
            ask('{8'h89, 8'h02});
        end
        // first id needs stuffing in both directions
        for (int j = 0; j < 2; j++) begin
            rnd(r);
            fid = (j == 0) ? 8'h7E : r[39:32];
            frame_len_ms <= r[31:0];
            put({8'h8A, 8'h03, 8'h00, 8'h05, fid, r[31:0]}, 9);
            ask('{8'h89, 8'h03, fid});
            `CHK(frame_id, fid)
        end
        rnd(r);
        rnd(r2);
        k1 = {r, r2[63:16], 8'h7E, 8'h7D};
        req = '{8'h87, 8'h04};
        for (int i = 15; i >= 0; i--) req.push_back(k1[8*i +: 8]);
        put(32'h88040000, 4);
        ask(req);
        `CHK(we_cnt, 1)
        `CHK(key_nv, k1)
        `CHK(key_active, k0)
        pulse_reset();
        `CHK(key_active, k1)
        // last two: network id set is not served here, frame length without its id byte
        for (int j = 0; j < 7; j++) begin
            put({(bcmd[j] == 8'h87) ? 8'h88 : 8'h8A, bpar[j], 8'h02, 8'h00}, 4);
            ask('{bcmd[j], bpar[j]});
        end
        // a reply to this frame is reported by the checker as unexpected
        mph_host_model_i.send('{8'h89, 8'h02}, 1'b1);
        repeat (40) @(posedge mclk);
        slow <= 1'b1;
        rnd(r);
        rnd(r2);
        rnd(r3);
        conn_state <= MPH_CS_ONLINE_MULTI_PARENT;
        ts_cycle <= r[63:32];
        ts_offset_us <= r[31:0];
        ts_frame_slots <= r2[63:48];
        ts_utc_s <= r2[47:16];
        ts_utc_us <= r3[63:32];
        ts_uptime_ms <= r3[31:0];
        put(32'h8A050017, 4);
        put(r, 8);
        put(r2[63:16], 6);
        put(r3, 8);
        put(8'h0A, 1);
        ask('{8'h89, 8'h05});
        rnd(r);
        rnd(r2);
        rnd(r3);
        rnd(r4);
        prop_mac <= r;
        prop_sheet_id <= r2;
        {prop_sw_rev, prop_hw_rev, prop_node_id} <= r3;
        {prop_hw_model, prop_net_id} <= r4[39:0];
        put(32'h8A07001F, 4);
        put({r4[39:16], r3[31:16], r3[63:32]}, 9);
        put(r, 8);
        put({8'h01, r4[15:0]}, 3);
        put(r2, 8);
        put({r3[15:0], 8'h00}, 3);
        ask('{8'h89, 8'h07});
        results();
    end
endmodule
